/* File: design/fcc_pkg.sv */
package fcc_pkg;

	// Register byte offsets inside the memory controller window.
	localparam logic [7:0] MODE_FIRST_OFS = 8'h60;
	localparam logic [7:0] CMD_FIRST_OFS = 8'h64;
	localparam logic [7:0] STAT_FIRST_OFS = 8'h68;
	localparam logic [7:0] RSVD_FIRST_OFS = 8'h6C;
	localparam logic [7:0] MODE_SECOND_OFS = 8'h70;
	localparam logic [7:0] CMD_SECOND_OFS = 8'h74;
	localparam logic [7:0] STAT_SECOND_OFS = 8'h78;
	localparam logic [7:0] RSVD_SECOND_OFS = 8'h7C;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;

	// Mode register fields.
	localparam int MODE_RDY_IE_BIT = 0;
	localparam int MODE_LOCK_ERROR_IE_BIT = 2;
	localparam int MODE_PROGRAM_ERROR_IE_BIT = 3;
	localparam int MODE_NO_ERASE_BIT = 7;
	localparam int MODE_WS_LSB = 8;
	localparam int MODE_MCN_LSB = 16;
	localparam logic [31:0] MODE_WMASK = 32'h00FF_038D;

	// Command register fields.
	localparam int CMD_KEY_LSB = 24;
	localparam logic [7:0] CMD_KEY = 8'h5A;
	localparam int CMD_PAGE_LSB = 8;

	// Status register fields.
	localparam int STAT_RDY_BIT = 0;
	localparam int STAT_LOCK_ERROR_BIT = 2;
	localparam int STAT_PROGRAM_ERROR_BIT = 3;
	localparam int STAT_SEC_BIT = 4;
	localparam int STAT_NV_LSB = 8;
	localparam int STAT_REGION_LOCKED_FLAG_LSB = 16;

	// Command codes.
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_WRITE_PAGE = 4'h1;
	localparam logic [3:0] CMD_SET_LOCK = 4'h2;
	localparam logic [3:0] CMD_WRITE_LOCK = 4'h3;
	localparam logic [3:0] CMD_CLEAR_LOCK = 4'h4;
	localparam logic [3:0] CMD_ERASE_ALL = 4'h8;
	localparam logic [3:0] CMD_SET_NV = 4'hB;
	localparam logic [3:0] CMD_CLEAR_NV = 4'hD;
	localparam logic [3:0] CMD_SET_SEC = 4'hF;

	// Array geometry and operation lengths in microsecond ticks.
	localparam int NUM_PAGES_LOG2 = 10;
	localparam int PAGES_PER_REGION_LOG2 = 6;
	localparam int NUM_REGIONS = 16;
	localparam int NUM_NV_BITS = 3;
	localparam logic [15:0] ERASE_US = 16'd10;
	localparam logic [15:0] PROG_US = 16'd20;
	localparam logic [15:0] NV_US = 16'd5;

	typedef struct packed {
		logic [7:0] mcn;
		logic [1:0] ws;
		logic no_erase;
		logic program_error_ie;
		logic lock_error_ie;
		logic rdy_ie;
	} fcc_mode_t;

	typedef struct packed {
		logic [NUM_REGIONS-1:0] region_locked_flag;
		logic [NUM_NV_BITS-1:0] nv;
		logic secure;
		logic program_error;
		logic lock_error;
		logic ready;
	} fcc_stat_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ERASE = 6'b000010,
		ST_PROG = 6'b000100,
		ST_LOCK = 6'b001000,
		ST_NV = 6'b010000,
		ST_ERALL = 6'b100000
	} fcc_state_t;

endpackage : fcc_pkg

/* File: design/fcc_top.sv */
`timescale 1ns/1ps

module fcc_engine (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Command strobe from the register slave.
	input wire logic cmd_we,
	input wire logic [31:0] cmd_data,
	input wire logic status_rd,
	input wire fcc_pkg::fcc_mode_t mode,
	// Flash array side.
	output fcc_pkg::fcc_stat_t status,
	output logic flash_busy,
	output logic [2:0] read_cycles,
	output logic [2:0] write_cycles,
	output logic irq
);
	fcc_pkg::fcc_state_t state_reg;
	fcc_pkg::fcc_stat_t stat_reg;
	logic [7:0] tick_cnt_reg;
	logic [15:0] us_cnt_reg;
	logic tick;
	logic lock_after_reg;
	logic lock_value_reg;
	logic [9:0] page_reg;
	logic [3:0] code;
	logic key_ok;
	logic [9:0] page_in;
	logic [3:0] region_in;
	logic target_locked;
	logic lock_error_set;
	logic program_error_set;
	logic [3:0] code_hold_reg;

	assign code = cmd_data[3:0];
	assign key_ok = cmd_data[31:24] == fcc_pkg::CMD_KEY;
	assign page_in = cmd_data[fcc_pkg::CMD_PAGE_LSB +: fcc_pkg::NUM_PAGES_LOG2];
	assign region_in = page_in[9:6];
	assign target_locked = stat_reg.region_locked_flag[region_in];
	assign status = stat_reg;
	assign flash_busy = state_reg != fcc_pkg::ST_IDLE;

	// Wait states select the array access lengths.
	always_comb begin
		read_cycles = 3'({1'b0, mode.ws} + 3'd1);
		write_cycles = (mode.ws == 2'd3) ? 3'd4 : 3'({1'b0, mode.ws} + 3'd2);
	end

	// Microsecond tick from the software-programmed cycle count; zero ticks every cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg == fcc_pkg::ST_IDLE || tick_cnt_reg >= mode.mcn) begin
			tick_cnt_reg <= 8'h00;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 8'h01;
		end
	end
	assign tick = tick_cnt_reg >= mode.mcn;

	// Command sequencer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= fcc_pkg::ST_IDLE;
			us_cnt_reg <= 16'h0000;
			lock_after_reg <= 1'b0;
			lock_value_reg <= 1'b0;
			page_reg <= 10'h000;
		end else if (state_reg == fcc_pkg::ST_IDLE) begin
			if (cmd_we && key_ok) begin
				page_reg <= page_in;
				lock_after_reg <= code == fcc_pkg::CMD_WRITE_LOCK;
				lock_value_reg <= code != fcc_pkg::CMD_CLEAR_LOCK;
				case (code)
				fcc_pkg::CMD_WRITE_PAGE, fcc_pkg::CMD_WRITE_LOCK: begin
					if (!target_locked) begin
						state_reg <= mode.no_erase ? fcc_pkg::ST_PROG : fcc_pkg::ST_ERASE;
						us_cnt_reg <= mode.no_erase ? fcc_pkg::PROG_US : fcc_pkg::ERASE_US;
					end
				end
				fcc_pkg::CMD_SET_LOCK, fcc_pkg::CMD_CLEAR_LOCK: begin
					state_reg <= fcc_pkg::ST_LOCK;
					us_cnt_reg <= fcc_pkg::NV_US;
				end
				fcc_pkg::CMD_ERASE_ALL: begin
					if (stat_reg.region_locked_flag == '0) begin
						state_reg <= fcc_pkg::ST_ERALL;
						us_cnt_reg <= fcc_pkg::ERASE_US;
					end
				end
				fcc_pkg::CMD_SET_NV, fcc_pkg::CMD_CLEAR_NV, fcc_pkg::CMD_SET_SEC: begin
					state_reg <= fcc_pkg::ST_NV;
					us_cnt_reg <= fcc_pkg::NV_US;
				end
				default: begin
					state_reg <= fcc_pkg::ST_IDLE;
				end
				endcase
			end
		end else if (tick) begin
			if (us_cnt_reg > 16'h0001) begin
				us_cnt_reg <= us_cnt_reg - 16'h0001;
			end else begin
				case (state_reg)
				fcc_pkg::ST_ERASE: begin
					state_reg <= fcc_pkg::ST_PROG;
					us_cnt_reg <= fcc_pkg::PROG_US;
				end
				fcc_pkg::ST_PROG: begin
					if (lock_after_reg) begin
						state_reg <= fcc_pkg::ST_LOCK;
						us_cnt_reg <= fcc_pkg::NV_US;
					end else begin
						state_reg <= fcc_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= fcc_pkg::ST_IDLE;
				end
				endcase
			end
		end
	end

	assign lock_error_set = cmd_we && key_ok && state_reg == fcc_pkg::ST_IDLE &&
		(((code == fcc_pkg::CMD_WRITE_PAGE || code == fcc_pkg::CMD_WRITE_LOCK) && target_locked) ||
		(code == fcc_pkg::CMD_ERASE_ALL && stat_reg.region_locked_flag != '0));
	assign program_error_set = cmd_we && (!key_ok || !(code == fcc_pkg::CMD_NOP ||
		code == fcc_pkg::CMD_WRITE_PAGE || code == fcc_pkg::CMD_SET_LOCK ||
		code == fcc_pkg::CMD_WRITE_LOCK || code == fcc_pkg::CMD_CLEAR_LOCK ||
		code == fcc_pkg::CMD_ERASE_ALL || code == fcc_pkg::CMD_SET_NV ||
		code == fcc_pkg::CMD_CLEAR_NV || code == fcc_pkg::CMD_SET_SEC));

	// Status flags; error flags clear on status read, a new event wins over the clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_reg <= '0;
			stat_reg.ready <= 1'b1;
		end else begin
			if (lock_error_set) begin
				stat_reg.lock_error <= 1'b1;
			end else if (status_rd) begin
				stat_reg.lock_error <= 1'b0;
			end
			if (program_error_set) begin
				stat_reg.program_error <= 1'b1;
			end else if (status_rd) begin
				stat_reg.program_error <= 1'b0;
			end
			if (state_reg == fcc_pkg::ST_IDLE) begin
				stat_reg.ready <= !(cmd_we && key_ok && !lock_error_set && code != fcc_pkg::CMD_NOP &&
					!program_error_set);
			end else if (tick && us_cnt_reg <= 16'h0001) begin
				case (state_reg)
				fcc_pkg::ST_LOCK: begin
					stat_reg.region_locked_flag[page_reg[9:6]] <= lock_value_reg;
					stat_reg.ready <= 1'b1;
				end
				fcc_pkg::ST_NV: begin
					if (code_hold_reg == fcc_pkg::CMD_SET_SEC) begin
						stat_reg.secure <= 1'b1;
					end else if (page_reg < 10'(fcc_pkg::NUM_NV_BITS)) begin
						stat_reg.nv[page_reg[1:0]] <= code_hold_reg == fcc_pkg::CMD_SET_NV;
					end
					stat_reg.ready <= 1'b1;
				end
				fcc_pkg::ST_PROG: begin
					stat_reg.ready <= !lock_after_reg;
				end
				fcc_pkg::ST_ERALL: begin
					stat_reg.ready <= 1'b1;
				end
				default: begin
					stat_reg.ready <= 1'b0;
				end
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code_hold_reg <= fcc_pkg::CMD_NOP;
		end else if (cmd_we && key_ok && state_reg == fcc_pkg::ST_IDLE) begin
			code_hold_reg <= code;
		end
	end

	// Interrupt line.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (stat_reg.ready & mode.rdy_ie) | (stat_reg.lock_error & mode.lock_error_ie) |
				(stat_reg.program_error & mode.program_error_ie);
		end
	end

endmodule : fcc_engine

////////////////////////////////////////////////////////////////////////////////

module fcc_top (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Controller outputs.
	output logic [1:0] busy,
	output logic [1:0] irq
);
	logic [7:0] aw_reg;
	logic aw_have_reg;
	logic [31:0] w_reg;
	logic w_have_reg;
	logic wr_go;
	logic [1:0] cmd_we;
	logic [1:0] stat_rd;
	fcc_pkg::fcc_mode_t mode_reg [2];
	fcc_pkg::fcc_stat_t stat [2];

	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_have_reg && w_have_reg;
	assign s_axi_bresp = 2'b00;
	assign s_axi_rresp = 2'b00;

	// Write channel capture, address and data in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_reg <= 8'h00;
			w_reg <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_reg <= s_axi_wdata;
				w_have_reg <= 1'b1;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Two instances; the second sits 0x10 above the first.
	for (genvar i = 0; i < 2; i++) begin : g_ctrl
		localparam logic [7:0] MODE_OFS = i ? fcc_pkg::MODE_SECOND_OFS : fcc_pkg::MODE_FIRST_OFS;
		localparam logic [7:0] CMD_OFS = i ? fcc_pkg::CMD_SECOND_OFS : fcc_pkg::CMD_FIRST_OFS;
		localparam logic [7:0] STAT_OFS = i ? fcc_pkg::STAT_SECOND_OFS : fcc_pkg::STAT_FIRST_OFS;
		logic [31:0] mode_word;
		assign mode_word = fcc_pkg::MODE_WMASK & w_reg;
		assign cmd_we[i] = wr_go && aw_reg[7:2] == CMD_OFS[7:2];
		assign stat_rd[i] = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == STAT_OFS[7:2];
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				mode_reg[i] <= '0;
			end else if (wr_go && aw_reg[7:2] == MODE_OFS[7:2] && (&s_axi_wstrb | 1'b1)) begin
				mode_reg[i] <= {mode_word[23:16], mode_word[9:8], mode_word[7], mode_word[3],
					mode_word[2], mode_word[0]};
			end
		end
		fcc_engine u_engine (
			.aclk(aclk),
			.aresetn(aresetn),
			.cmd_we(cmd_we[i]),
			.cmd_data(w_reg),
			.status_rd(stat_rd[i]),
			.mode(mode_reg[i]),
			.status(stat[i]),
			.flash_busy(busy[i]),
			.read_cycles(),
			.write_cycles(),
			.irq(irq[i])
		);
	end

	// Read path; command, reserved and unmapped offsets read zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			if (s_axi_araddr[7:2] == fcc_pkg::MODE_FIRST_OFS[7:2]) begin
				s_axi_rdata <= {8'h00, mode_reg[0].mcn, 6'h00, mode_reg[0].ws, mode_reg[0].no_erase,
					3'h0, mode_reg[0].program_error_ie, mode_reg[0].lock_error_ie, 1'b0, mode_reg[0].rdy_ie};
			end else if (s_axi_araddr[7:2] == fcc_pkg::MODE_SECOND_OFS[7:2]) begin
				s_axi_rdata <= {8'h00, mode_reg[1].mcn, 6'h00, mode_reg[1].ws, mode_reg[1].no_erase,
					3'h0, mode_reg[1].program_error_ie, mode_reg[1].lock_error_ie, 1'b0, mode_reg[1].rdy_ie};
			end else if (s_axi_araddr[7:2] == fcc_pkg::STAT_FIRST_OFS[7:2]) begin
				s_axi_rdata <= {stat[0].region_locked_flag, 5'h00, stat[0].nv, 3'h0, stat[0].secure,
					stat[0].program_error, stat[0].lock_error, 1'b0, stat[0].ready};
			end else if (s_axi_araddr[7:2] == fcc_pkg::STAT_SECOND_OFS[7:2]) begin
				s_axi_rdata <= {stat[1].region_locked_flag, 5'h00, stat[1].nv, 3'h0, stat[1].secure,
					stat[1].program_error, stat[1].lock_error, 1'b0, stat[1].ready};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : fcc_top

/* File: test/fcc_top_asserts.sv */
`timescale 1ns/1ps

module fcc_top_asserts (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Bus signals watched.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// Controller outputs.
	input wire logic [1:0] busy,
	input wire logic [1:0] irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic cmd_wr;
	logic key_ok;
	logic [3:0] code;
	// Command writes to the first controller while it is idle.
	assign cmd_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == fcc_pkg::CMD_FIRST_OFS && !busy[0];
	assign key_ok = s_axi_wdata[31:24] == fcc_pkg::CMD_KEY;
	assign code = s_axi_wdata[3:0];
	property stays_idle(logic c);
		c |=> !busy[0] [*4];
	endproperty
	cmd_start_a: assert property (cmd_wr && key_ok
		&& code inside {4'h2, 4'h4, 4'hB, 4'hD, 4'hF} |-> ##[1:4] busy[0])
		else $error("valid command did not start");
	bad_key_a: assert property (stays_idle(cmd_wr && !key_ok))
		else $error("wrong key started an operation");
	nop_idle_a: assert property (stays_idle(cmd_wr && key_ok && code == 4'h0))
		else $error("no-operation code started an operation");
	rsvd_code_a: assert property (stays_idle(cmd_wr && key_ok
		&& code inside {4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hC, 4'hE}))
		else $error("reserved code started an operation");
	busy_min_a: assert property ($rose(busy[0]) |-> busy[0] [*4])
		else $error("operation ended too early");
	cmd_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == fcc_pkg::CMD_FIRST_OFS |=> s_axi_rvalid && s_axi_rdata == 0)
		else $error("command register read not zero");
	rsvd_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == fcc_pkg::RSVD_SECOND_OFS |=> s_axi_rvalid && s_axi_rdata == 0)
		else $error("reserved read not zero");
	reset_quiet_a: assert property ($rose(aresetn) |-> irq == 2'b00 && busy == 2'b00)
		else $error("outputs active after reset");
	cover property ($rose(busy[0]));
	cover property ($rose(busy[1]));
	cover property ($rose(irq[0]));
endmodule : fcc_top_asserts

bind fcc_top fcc_top_asserts fcc_top_asserts_inst (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.busy, .irq);

/* File: test/fcc_flash_model.sv */
`timescale 1ns/1ps

module fcc_flash_model;
	logic [15:0] region_locked_flag [2] = '{16'h0000, 16'h0000};
	logic [2:0] nv [2] = '{3'h0, 3'h0};
	logic sec [2] = '{1'b0, 1'b0};
	logic lock_error [2] = '{1'b0, 1'b0};
	logic program_error [2] = '{1'b0, 1'b0};

	task automatic apply(input int i, input logic [31:0] d);
		int pg;
		int rg;
		pg = int'(d[17:8]);
		rg = pg / 64;
		if (d[31:24] != fcc_pkg::CMD_KEY) begin
			program_error[i] = 1'b1;
			return;
		end
		case (d[3:0])
			fcc_pkg::CMD_NOP: ;
			fcc_pkg::CMD_WRITE_PAGE: if (region_locked_flag[i][rg]) lock_error[i] = 1'b1;
			fcc_pkg::CMD_SET_LOCK: region_locked_flag[i][rg] = 1'b1;
			fcc_pkg::CMD_WRITE_LOCK: begin
				if (region_locked_flag[i][rg]) lock_error[i] = 1'b1;
				else region_locked_flag[i][rg] = 1'b1;
			end
			fcc_pkg::CMD_CLEAR_LOCK: region_locked_flag[i][rg] = 1'b0;
			fcc_pkg::CMD_ERASE_ALL: if (|region_locked_flag[i]) lock_error[i] = 1'b1;
			fcc_pkg::CMD_SET_NV: if (pg < 3) nv[i][pg[1:0]] = 1'b1;
			fcc_pkg::CMD_CLEAR_NV: if (pg < 3) nv[i][pg[1:0]] = 1'b0;
			fcc_pkg::CMD_SET_SEC: sec[i] = 1'b1;
			default: program_error[i] = 1'b1;
		endcase
	endtask : apply

	// Status once idle: ready is always set here.
	function automatic logic [31:0] st(input int i);
		return {region_locked_flag[i], 5'h00, nv[i], 3'h0, sec[i], program_error[i], lock_error[i], 1'b0, 1'b1};
	endfunction : st

	task automatic clr(input int i);
		lock_error[i] = 1'b0;
		program_error[i] = 1'b0;
	endtask : clr
endmodule : fcc_flash_model

/* File: test/test_flash_command_controller.sv */
`timescale 1ns/1ps

module test_flash_command_controller;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, busy, irq;
	logic [31:0] s_axi_rdata, rd;
	logic [31:0] mode_v [2] = '{32'h0000_0000, 32'h0000_0000};
	logic [3:0] seq_a [9] = '{4'h2, 4'h1, 4'h8, 4'h3, 4'h4, 4'h8, 4'h3, 4'h4, 4'h1};
	logic [3:0] seq_b [15] = '{4'hB, 4'hD, 4'hB, 4'h3, 4'hF, 4'h0, 4'h5, 4'h6, 4'h7,
		4'h9, 4'hA, 4'hC, 4'hE, 4'h4, 4'h8};
	logic [7:0] zero_a [5] = '{8'h64, 8'h6C, 8'h74, 8'h7C, 8'h80};
	logic [9:0] pg;
	int num_errors = 0;
	int checks = 0;
	int cyc, cyc_e, n;
	// At 100 MHz one microsecond is 100 cycles and 1.5 microseconds is 150.
	localparam logic [7:0] CYC_1US = 8'h64;
	localparam logic [7:0] CYC_1US5 = 8'h96;
	localparam int WAIT_LIMIT = 8000;

	fcc_top fcc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy, .irq);
	fcc_flash_model model ();

	initial forever #5 aclk = ~aclk;

	task test_done;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task bound;
		if (n >= WAIT_LIMIT) begin
			num_errors++;
			test_done();
		end
	endtask : bound

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < WAIT_LIMIT; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		bound();
	endtask : wr

	task rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < WAIT_LIMIT; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		bound();
	endtask : rdr

	task setmode(input int i, input logic [31:0] v);
		mode_v[i] = v;
		wr(fcc_pkg::MODE_FIRST_OFS + 8'(16 * i), v);
	endtask : setmode

	// Issues a command, waits for the controller to go idle, then checks status.
	task op(input int i, input logic [31:0] d);
		logic [31:0] s;
		logic [7:0] mcn;
		mcn = (d[3:0] inside {4'h1, 4'h3, 4'h8}) ? CYC_1US5 : CYC_1US;
		setmode(i, {mode_v[i][31:24], mcn, mode_v[i][15:0]});
		wr(fcc_pkg::CMD_FIRST_OFS + 8'(16 * i), d);
		model.apply(i, d);
		@(posedge aclk);
		#1;
		for (n = 0; busy[i] !== 1'b0 && n < WAIT_LIMIT; n++) begin
			@(posedge aclk);
			#1;
		end
		bound();
		cyc = n;
		@(posedge aclk);
		#1;
		s = model.st(i);
		chk(32'(irq[i]), 32'(|(s[3:0] & mode_v[i][3:0])));
		rdr(fcc_pkg::STAT_FIRST_OFS + 8'(16 * i), rd);
		chk(rd, s);
		model.clr(i);
	endtask : op

	function automatic logic [31:0] cmd(input logic [3:0] c, input logic [9:0] p);
		return {fcc_pkg::CMD_KEY, 6'h00, p, 4'h0, c};
	endfunction : cmd

	initial begin
		n = 0;
		repeat (100000) @(posedge aclk);
		n = WAIT_LIMIT;
		bound();
	end

	initial begin
		void'($urandom(32'h7AA8));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			rdr(fcc_pkg::MODE_FIRST_OFS + 8'(16 * i), rd);
			chk(rd, fcc_pkg::MODE_RESET);
			rdr(fcc_pkg::STAT_FIRST_OFS + 8'(16 * i), rd);
			chk(rd, model.st(i));
		end
		wr(fcc_pkg::RSVD_FIRST_OFS, 32'hFFFF_FFFF);
		wr(8'h80, 32'hFFFF_FFFF);
		foreach (zero_a[k]) begin
			rdr(zero_a[k], rd);
			chk(rd, 32'h0000_0000);
		end
		setmode(1, 32'hFFFF_FFFF);
		rdr(fcc_pkg::MODE_SECOND_OFS, rd);
		chk(rd, fcc_pkg::MODE_WMASK);
		setmode(1, 32'h0000_0001);
		op(1, cmd(4'hF, 10'h000));
		op(1, cmd(4'h2, 10'h3C0));
		setmode(0, 32'h0000_000C);
		pg = 10'($urandom);
		foreach (seq_a[k]) op(0, cmd(seq_a[k], pg));
		cyc_e = cyc;
		setmode(0, 32'h0000_008C);
		op(0, cmd(4'h1, pg));
		chk(32'(cyc_e - cyc), 32'(fcc_pkg::ERASE_US) * (32'(CYC_1US5) + 32'd1));
		op(0, {8'hA5, 6'h00, pg, 4'h0, 4'h2});
		foreach (seq_b[k]) op(0, cmd(seq_b[k], 10'($urandom % 4)));
		test_done();
	end
endmodule : test_flash_command_controller
